/* pkg/crd_pkg.sv */
// Shared constants and types for the central register and multiplexer datapath.
// Assumes a single clock domain; sequencing control supplies one-cycle phase enables.
package crd_pkg;
   localparam int WORD_W = 12;         // Machine word width
   localparam int BUF_W = 24;          // Memory buffer width
   localparam int CLASS_MSB = 11;      // Top of the leading type field
   localparam int CLASS_LSB = 8;       // Bottom of the leading type field
   localparam int LITERAL_MSB = 11; // Top of the partial literal word
   localparam int LITERAL_LSB = 6; // Bottom of the partial literal word
   localparam int CTRL_MSB = 11;       // Top of the bits kept for control
   localparam int CTRL_LSB = 5;        // Bottom of the bits kept for control
   localparam int TWO_WORD_SHIFT = 3;  // Left shift in the second basic phase
   localparam int STAT_FIELD_W = 2;    // Width of each memory field in status
   localparam logic [11:0] WORD_RST = 12'h000; // Value after reset
   localparam logic [23:0] BUF_RST = 24'h000000; // Buffer value after reset
   localparam logic [3:0] OPR1_CODE = 4'h0;  // Leading code, operate class one
   localparam logic [3:0] OPR2_CODE = 4'h1;  // Leading code, operate class two
   localparam logic [3:0] LITERAL_CODE = 4'h2; // Leading code, literal
   localparam logic [3:0] IO_CODE = 4'h3;    // Leading code, input-output

   // Operand B sources
   typedef enum logic [1:0] {
      CRD_B_ACC1 = 2'h0,
      CRD_B_ACC2 = 2'h1,
      CRD_B_MDATA = 2'h2,
      CRD_B_LITERAL = 2'h3
   } crd_bsel_t;

   // Operand A sources
   typedef enum logic [2:0] {
      CRD_A_ACC2 = 3'h0,
      CRD_A_ACC1 = 3'h1,
      CRD_A_SUB2 = 3'h2,
      CRD_A_SUB1 = 3'h3,
      CRD_A_LOC = 3'h4,
      CRD_A_PC = 3'h5,
      CRD_A_STAT = 3'h6,
      CRD_A_UTIL = 3'h7
   } crd_asel_t;

   // Utility gate sources
   typedef enum logic [1:0] {
      CRD_U_ACC1 = 2'h0,
      CRD_U_ACC2 = 2'h1,
      CRD_U_PERIPH = 2'h2,
      CRD_U_PANEL = 2'h3
   } crd_usel_t;

   // Add/subtract function
   typedef enum logic [1:0] {
      CRD_F_PASS = 2'h0,
      CRD_F_ADD = 2'h1,
      CRD_F_SUB = 2'h2
   } crd_func_t;
endpackage : crd_pkg

/* pkg/crd_adder_if.sv */
// Operand paths between the datapath and its adder.
// Assumes the adder is purely combinational.
interface crd_adder_if;
   logic [11:0] op_a;   // Operand A word
   logic [11:0] op_b;   // Operand B after add/subtract gates
   logic carry_in;      // Add-one for subtraction
   logic [11:0] sum;    // Sum bus
   logic carry_out;     // Carry out of top bit
   modport core (output op_a, output op_b, output carry_in, input sum, input carry_out);
   modport adder (input op_a, input op_b, input carry_in, output sum, output carry_out);
endinterface : crd_adder_if

/* core/crd_ripple_adder.sv */
// Twelve-bit ripple-carry adder feeding the sum bus.
// Assumes operands are settled within the same cycle.
module crd_ripple_adder (
   crd_adder_if.adder add_if  // Operand and sum paths
);
   logic [12:0] carry;

   // Carry chain entry and exit
   assign carry[0] = add_if.carry_in;
   assign add_if.carry_out = carry[12];

   // One full adder per bit, carry rippling upward
   genvar g;
   generate
      for (g = 0; g < 12; g++) begin : g_bit
         assign add_if.sum[g] = add_if.op_a[g] ^ add_if.op_b[g] ^ carry[g];
         assign carry[g + 1] = (add_if.op_a[g] & add_if.op_b[g]) | (carry[g] & (add_if.op_a[g] ^ add_if.op_b[g]));
      end
   endgenerate
endmodule : crd_ripple_adder

/* core/crd_datapath.sv */
// Central register and multiplexer datapath of a 12-bit processor.
// Assumes sequencing control drives one-cycle phase enables on mclk_i and
// that memory sense data is already synchronous to mclk_i.
module crd_datapath (
   input wire logic mclk_i,                  // 20 MHz clock
   input wire logic rst_b_i,                 // Async reset, active low
   input wire logic basic_phase_i,           // Basic phase active
   input wire logic cycle_start_i,           // Start of machine cycle
   input wire logic phase_start_i,           // Start of any phase
   input wire logic second_basic_i,          // Second basic phase of two-word
   input wire logic instr_load_i,            // Load instruction latch
   input wire logic loc_load_i,              // Load location latch from sum
   input wire logic pc_load_i,               // Load next fetch counter from sum
   input wire logic sense_load_i,            // Load buffer from sense amps
   input wire logic mword_load_i,            // Load memory word latch
   input wire logic bufsel_mem_i,            // Bus/buffer mux: 1 buffer, 0 sum
   input wire logic bufsel_hi_i,             // Take upper buffer half
   input wire logic [1:0] bsel_i,            // Operand B select
   input wire logic [2:0] asel_i,            // Operand A select
   input wire logic [1:0] usel_i,            // Utility gate select
   input wire logic [1:0] func_i,            // Pass, add or subtract
   input wire logic acc1_load_i,             // Load first main from sum
   input wire logic acc2_load_i,             // Load second main from sum
   input wire logic sub1_from_acc_i,         // First sub from first main
   input wire logic sub2_from_acc_i,         // Second sub from second main
   input wire logic acc1_from_sub_i,         // First main from first sub
   input wire logic acc2_from_sub_i,         // Second main from second sub
   input wire logic prod_load_i,             // Product into both subs
   input wire logic [11:0] prod_low_i,       // Product low word
   input wire logic [11:0] prod_high_i,      // Product high word
   input wire logic [23:0] sense_i,          // Memory sense outputs
   input wire logic [11:0] periph_i,         // Peripheral input word
   input wire logic [11:0] panel_i,          // Front panel switches
   input wire logic overflow_i,              // Overflow state
   input wire logic flag_i,                  // Flag flip-flop
   input wire logic [1:0] cur_field_i,       // Current memory field
   input wire logic [1:0] jsr_field_i,       // Subroutine-jump field
   input wire logic [1:0] int_field_i,       // Interrupt memory field
   output logic memory_reference_class_o,    // Memory reference type
   output logic operate_class_one_o,         // Operate class one
   output logic operate_class_two_o,         // Operate class two
   output logic literal_class_o,             // Literal type
   output logic io_class_o,                  // Input-output type
   output logic [6:0] instr_ctrl_o,          // Instruction bits 5-11
   output logic [11:0] mem_addr_o,           // Memory location
   output logic [11:0] pc_o,                 // Next fetch counter
   output logic [11:0] panel_word_display_o, // Memory word latch display
   output logic [11:0] sum_o,                // Sum bus
   output logic carry_o,                     // Adder carry out
   output logic [11:0] acc1_o,               // First main accumulator
   output logic [11:0] acc2_o                // Second main accumulator
);
   logic [11:0] instr_reg, instr_next;
   logic [11:0] loc_reg, loc_next;
   logic [11:0] pc_reg, pc_next;
   logic [23:0] buf_reg, buf_next;
   logic [11:0] mword_reg, mword_next;
   logic [11:0] acc1_reg, acc1_next;
   logic [11:0] acc2_reg, acc2_next;
   logic [11:0] sub1_reg, sub1_next;
   logic [11:0] sub2_reg, sub2_next;
   logic class_memref_reg, class_opr1_reg, class_opr2_reg, class_literal_reg, class_io_reg;
   wire [3:0] lead_bits;
   wire is_opr1, is_opr2, is_literal, is_io, is_memref;
   wire [11:0] buf_half;
   wire [11:0] bus_buf_word;
   wire [11:0] literal_word;
   wire [11:0] status_word;
   wire [11:0] util_word;
   wire [11:0] op_b_sel;
   wire [11:0] op_a_sel;
   wire [11:0] sum_bus;
   wire do_add, do_sub;

   crd_adder_if add_if ();

   // Adder instance
   crd_ripple_adder u_adder (
      .add_if (add_if.adder)
   );

   // Type decode of leading field
   assign lead_bits = instr_reg[crd_pkg::CLASS_MSB:crd_pkg::CLASS_LSB];
   assign is_opr1 = (lead_bits == crd_pkg::OPR1_CODE);
   assign is_opr2 = (lead_bits == crd_pkg::OPR2_CODE);
   assign is_literal = (lead_bits == crd_pkg::LITERAL_CODE);
   assign is_io = (lead_bits == crd_pkg::IO_CODE);
   assign is_memref = ~(is_opr1 | is_opr2 | is_literal | is_io);

   // Bus and buffer multiplexer
   assign buf_half = bufsel_hi_i ? buf_reg[23:12] : buf_reg[11:0];
   assign bus_buf_word = bufsel_mem_i ? buf_half : sum_bus;

   // Operand B multiplexer with literal partial word
   assign literal_word = {6'h00, instr_reg[crd_pkg::LITERAL_MSB:crd_pkg::LITERAL_LSB]};
   assign op_b_sel = (bsel_i == crd_pkg::CRD_B_ACC1) ? acc1_reg :
                     (bsel_i == crd_pkg::CRD_B_ACC2) ? acc2_reg :
                     (bsel_i == crd_pkg::CRD_B_MDATA) ? mword_reg : literal_word;

   // Status word and utility gates
   assign status_word = {4'h0, overflow_i, flag_i, cur_field_i, jsr_field_i, int_field_i};
   assign util_word = (usel_i == crd_pkg::CRD_U_ACC1) ? acc1_reg :
                      (usel_i == crd_pkg::CRD_U_ACC2) ? acc2_reg :
                      (usel_i == crd_pkg::CRD_U_PERIPH) ? periph_i : panel_i;

   // Operand A multiplexer
   assign op_a_sel = (asel_i == crd_pkg::CRD_A_ACC2) ? acc2_reg :
                     (asel_i == crd_pkg::CRD_A_ACC1) ? acc1_reg :
                     (asel_i == crd_pkg::CRD_A_SUB2) ? sub2_reg :
                     (asel_i == crd_pkg::CRD_A_SUB1) ? sub1_reg :
                     (asel_i == crd_pkg::CRD_A_LOC) ? loc_reg :
                     (asel_i == crd_pkg::CRD_A_PC) ? pc_reg :
                     (asel_i == crd_pkg::CRD_A_STAT) ? status_word : util_word;

   // Add/subtract gates
   assign do_add = (func_i == crd_pkg::CRD_F_ADD);
   assign do_sub = (func_i == crd_pkg::CRD_F_SUB);
   assign add_if.op_a = op_a_sel;
   assign add_if.op_b = do_add ? op_b_sel : (do_sub ? ~op_b_sel : 12'h000);
   assign add_if.carry_in = do_sub;
   assign sum_bus = add_if.sum;

   // Instruction latch next value: clear, shift, load
   always_comb begin
      instr_next = instr_reg;
      if (cycle_start_i) begin
         instr_next = crd_pkg::WORD_RST;
      end else if (second_basic_i) begin
         instr_next = instr_reg << crd_pkg::TWO_WORD_SHIFT;
      end else if (instr_load_i) begin
         instr_next = bus_buf_word;
      end
   end

   // Address, counter, buffer and memory word next values
   assign loc_next = loc_load_i ? sum_bus : loc_reg;
   assign pc_next = pc_load_i ? sum_bus : pc_reg;
   assign buf_next = phase_start_i ? crd_pkg::BUF_RST : (sense_load_i ? sense_i : buf_reg);
   assign mword_next = mword_load_i ? bus_buf_word : mword_reg;

   // Accumulator next values; subs reach only their paired main
   always_comb begin
      acc1_next = acc1_reg;
      acc2_next = acc2_reg;
      sub1_next = sub1_reg;
      sub2_next = sub2_reg;
      if (acc1_load_i) begin
         acc1_next = sum_bus;
      end else if (acc1_from_sub_i) begin
         acc1_next = sub1_reg;
      end
      if (acc2_load_i) begin
         acc2_next = sum_bus;
      end else if (acc2_from_sub_i) begin
         acc2_next = sub2_reg;
      end
      if (prod_load_i) begin
         sub1_next = prod_high_i;
         sub2_next = prod_low_i;
      end else begin
         if (sub1_from_acc_i) begin
            sub1_next = acc1_reg;
         end
         if (sub2_from_acc_i) begin
            sub2_next = acc2_reg;
         end
      end
   end

   // Datapath registers
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         instr_reg <= crd_pkg::WORD_RST;
         loc_reg <= crd_pkg::WORD_RST;
         pc_reg <= crd_pkg::WORD_RST;
         buf_reg <= crd_pkg::BUF_RST;
         mword_reg <= crd_pkg::WORD_RST;
      end else begin
         instr_reg <= instr_next;
         loc_reg <= loc_next;
         pc_reg <= pc_next;
         buf_reg <= buf_next;
         mword_reg <= mword_next;
      end
   end

   // Accumulator registers
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         acc1_reg <= crd_pkg::WORD_RST;
         acc2_reg <= crd_pkg::WORD_RST;
         sub1_reg <= crd_pkg::WORD_RST;
         sub2_reg <= crd_pkg::WORD_RST;
      end else begin
         acc1_reg <= acc1_next;
         acc2_reg <= acc2_next;
         sub1_reg <= sub1_next;
         sub2_reg <= sub2_next;
      end
   end

   // Type flags captured in basic phase
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         class_memref_reg <= 1'b0;
         class_opr1_reg <= 1'b0;
         class_opr2_reg <= 1'b0;
         class_literal_reg <= 1'b0;
         class_io_reg <= 1'b0;
      end else if (basic_phase_i) begin
         class_memref_reg <= is_memref;
         class_opr1_reg <= is_opr1;
         class_opr2_reg <= is_opr2;
         class_literal_reg <= is_literal;
         class_io_reg <= is_io;
      end
   end

   // Outputs from registers, plus the combinational sum and carry
   assign memory_reference_class_o = class_memref_reg;
   assign operate_class_one_o = class_opr1_reg;
   assign operate_class_two_o = class_opr2_reg;
   assign literal_class_o = class_literal_reg;
   assign io_class_o = class_io_reg;
   assign instr_ctrl_o = instr_reg[crd_pkg::CTRL_MSB:crd_pkg::CTRL_LSB];
   assign mem_addr_o = loc_reg;
   assign pc_o = pc_reg;
   assign panel_word_display_o = mword_reg;
   assign sum_o = sum_bus;
   assign carry_o = add_if.carry_out;
   assign acc1_o = acc1_reg;
   assign acc2_o = acc2_reg;
endmodule : crd_datapath

/* verification/crd_core_model.sv */
// Core memory stack model answering reads at the location latch address.
// Assumes the datapath samples the sense lines on its buffer load enable.
module crd_core_model (
   input wire logic mclk_i,          // System clock
   input wire logic rst_b_i,         // Async reset, active low
   input wire logic read_i,          // Sense amplifiers strobed
   input wire logic [11:0] addr_i,   // Location from the datapath
   output logic [23:0] sense_o       // Sense amplifier outputs
);
   logic [11:0] junk_reg;
   // Lines not strobed wander every cycle
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) junk_reg <= 12'h5A3;
      else junk_reg <= junk_reg + 12'h3B7;
   end
   // Stored word derived from the address
   assign sense_o = read_i ? {addr_i ^ 12'hA5A, addr_i} : {junk_reg, ~junk_reg};
endmodule : crd_core_model

/* verification/crd_datapath_asserts.sv */
// Port-level checks of the central datapath.
// Assumes one clock domain and async active-low reset.
module crd_datapath_asserts (
   input wire logic mclk_i, rst_b_i, basic_phase_i, cycle_start_i, phase_start_i, second_basic_i,
   input wire logic loc_load_i, pc_load_i, sense_load_i, mword_load_i, bufsel_mem_i, bufsel_hi_i, acc1_load_i,
   input wire logic [1:0] func_i, usel_i, bsel_i,
   input wire logic [2:0] asel_i,
   input wire logic [11:0] panel_i, mem_addr_o, pc_o, panel_word_display_o, sum_o, acc1_o,
   input wire logic [23:0] sense_i,
   input wire logic [6:0] instr_ctrl_o,
   input wire logic literal_class_o, memory_reference_class_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   // Register loads and holds
   a_loc_from_sum: assert property (loc_load_i |=> mem_addr_o == $past(sum_o)) else $error("location load wrong");
   a_loc_holds: assert property (!loc_load_i |=> $stable(mem_addr_o)) else $error("location moved");
   a_pc_from_sum: assert property (pc_load_i |=> pc_o == $past(sum_o)) else $error("counter load wrong");
   a_acc_from_sum: assert property (acc1_load_i |=> acc1_o == $past(sum_o)) else $error("main load wrong");
   // Adder operand paths
   a_add_true_b: assert property (func_i == 2'h1 && asel_i == 3'h7 && usel_i == 2'h3 && bsel_i == 2'h0
      |-> sum_o == panel_i + acc1_o) else $error("add path wrong");
   a_sub_twos: assert property (func_i == 2'h2 && asel_i == 3'h7 && usel_i == 2'h3 && bsel_i == 2'h0
      |-> sum_o == panel_i - acc1_o) else $error("subtract path wrong");
   a_pass_zero_b: assert property ((func_i == 2'h0 || func_i == 2'h3) && asel_i == 3'h7 && usel_i == 2'h3
      |-> sum_o == panel_i) else $error("pass path wrong");
   // Buffer to memory word latch
   a_buf_to_word: assert property (sense_load_i && !phase_start_i ##1 mword_load_i && bufsel_mem_i
      && !bufsel_hi_i && !sense_load_i && !phase_start_i |=> panel_word_display_o == $past(sense_i[11:0], 2))
      else $error("buffer word wrong");
   // Instruction latch handling
   a_cycle_clear: assert property (cycle_start_i |=> instr_ctrl_o == 7'h00) else $error("latch not cleared");
   a_shift_three: assert property (second_basic_i && !cycle_start_i
      |=> instr_ctrl_o[6:3] == $past(instr_ctrl_o[3:0])) else $error("shift wrong");
   a_literal_flag: assert property (basic_phase_i |=> literal_class_o == ($past(instr_ctrl_o[6:3]) == 4'h2))
      else $error("literal flag wrong");
   a_memref_flag: assert property (basic_phase_i
      |=> memory_reference_class_o == ($past(instr_ctrl_o[6:3]) > 4'h3)) else $error("memory reference flag wrong");
endmodule : crd_datapath_asserts
bind crd_datapath crd_datapath_asserts u_chk (.mclk_i, .rst_b_i, .basic_phase_i, .cycle_start_i, .phase_start_i,
   .second_basic_i, .loc_load_i, .pc_load_i, .sense_load_i, .mword_load_i, .bufsel_mem_i, .bufsel_hi_i, .acc1_load_i,
   .func_i, .usel_i, .bsel_i, .asel_i, .panel_i, .mem_addr_o, .pc_o, .panel_word_display_o, .sum_o, .acc1_o, .sense_i,
   .instr_ctrl_o, .literal_class_o, .memory_reference_class_o);

/* verification/crd_datapath_test.sv */
// Self-checking bench for the central datapath with a core memory model.
// Assumes inputs change on the falling clock edge.
module crd_datapath_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk_i = 0, rst_b_i = 0, basic_phase_i, cycle_start_i, phase_start_i, second_basic_i, instr_load_i;
   logic loc_load_i, pc_load_i, sense_load_i, mword_load_i, bufsel_mem_i, bufsel_hi_i, acc1_load_i, acc2_load_i;
   logic sub1_from_acc_i, sub2_from_acc_i, acc1_from_sub_i, acc2_from_sub_i, prod_load_i, overflow_i, flag_i;
   logic [1:0] bsel_i, usel_i, func_i, cur_field_i, jsr_field_i, int_field_i;
   logic [2:0] asel_i;
   logic [11:0] prod_low_i, prod_high_i, periph_i, panel_i, mem_addr_o, pc_o, panel_word_display_o;
   logic [11:0] sum_o, acc1_o, acc2_o;
   logic [23:0] sense_i;
   logic [6:0] instr_ctrl_o;
   logic memory_reference_class_o, operate_class_one_o, operate_class_two_o, literal_class_o, io_class_o, carry_o;
   int num_errors = 0, checks = 0, cycles = 0;
   logic [11:0] last_loc;
   logic [11:0] ea_addr [5] = '{12'h0A3, 12'h1F0, 12'h2C7, 12'h3E1, 12'hC5B};
   crd_datapath uut (.mclk_i, .rst_b_i, .basic_phase_i, .cycle_start_i, .phase_start_i, .second_basic_i, .instr_load_i,
      .loc_load_i, .pc_load_i, .sense_load_i, .mword_load_i, .bufsel_mem_i, .bufsel_hi_i, .bsel_i, .asel_i, .usel_i,
      .func_i, .acc1_load_i, .acc2_load_i, .sub1_from_acc_i, .sub2_from_acc_i, .acc1_from_sub_i, .acc2_from_sub_i,
      .prod_load_i, .prod_low_i, .prod_high_i, .sense_i, .periph_i, .panel_i, .overflow_i, .flag_i, .cur_field_i,
      .jsr_field_i, .int_field_i, .memory_reference_class_o, .operate_class_one_o, .operate_class_two_o,
      .literal_class_o, .io_class_o, .instr_ctrl_o, .mem_addr_o, .pc_o, .panel_word_display_o, .sum_o, .carry_o,
      .acc1_o, .acc2_o);
   crd_core_model mem (.mclk_i, .rst_b_i, .read_i(sense_load_i), .addr_i(mem_addr_o), .sense_o(sense_i));
   // Clock and hang guard
   initial forever #25 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         report_and_stop();
      end
   end
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic clr();
      {basic_phase_i, cycle_start_i, phase_start_i, second_basic_i, instr_load_i, loc_load_i, pc_load_i, sense_load_i,
       mword_load_i, acc1_load_i, acc2_load_i, sub1_from_acc_i, sub2_from_acc_i, acc1_from_sub_i, acc2_from_sub_i,
       prod_load_i} = '0;
   endtask : clr
   // One clock with the pulses set, then drop them
   task automatic nx();
      @(negedge mclk_i);
      clr();
   endtask : nx
   task automatic panel_sum(input logic [11:0] v);
      asel_i = 3'h7;
      usel_i = 2'h3;
      func_i = 2'h0;
      panel_i = v;
   endtask : panel_sum
   task automatic fetch(input logic [11:0] a);
      logic [3:0] n;
      n = a[11:8];
      panel_sum(a);
      loc_load_i = 1;
      nx();
      last_loc = a;
      check(mem_addr_o, a);
      sense_load_i = 1;
      nx();
      bufsel_mem_i = 1;
      bufsel_hi_i = 0;
      mword_load_i = 1;
      instr_load_i = 1;
      nx();
      check(panel_word_display_o, a);
      check(instr_ctrl_o, a[11:5]);
      basic_phase_i = 1;
      nx();
      check({memory_reference_class_o, operate_class_one_o, operate_class_two_o, literal_class_o, io_class_o},
         {n > 4'h3, n == crd_pkg::OPR1_CODE, n == crd_pkg::OPR2_CODE,
          n == crd_pkg::LITERAL_CODE, n == crd_pkg::IO_CODE});
      bufsel_hi_i = 1;
      mword_load_i = 1;
      nx();
      check(panel_word_display_o, a ^ 12'hA5A);
      phase_start_i = 1;
      sense_load_i = 1;
      nx();
      bufsel_hi_i = 0;
      mword_load_i = 1;
      nx();
      check(panel_word_display_o, 12'h000);
      check(instr_ctrl_o, a[11:5]);
   endtask : fetch
   task automatic ir_ops();
      logic [11:0] w;
      w = 12'hC5B;
      bufsel_mem_i = 0;
      panel_sum(w);
      instr_load_i = 1;
      nx();
      check(instr_ctrl_o, w[11:5]);
      second_basic_i = 1;
      instr_load_i = 1;
      nx();
      w = w << 3;
      check(instr_ctrl_o, w[11:5]);
      panel_i = 12'h100;
      func_i = 2'h1;
      bsel_i = 2'h3;
      nx();
      check(sum_o, 12'h100 + (w >> 6));
      cycle_start_i = 1;
      second_basic_i = 1;
      nx();
      check(instr_ctrl_o, 7'h00);
   endtask : ir_ops
   task automatic arith();
      logic [11:0] x, y;
      logic [12:0] e;
      logic [11:0] ea [10];
      x = 12'h9C4;
      y = 12'h7A5;
      panel_sum(y);
      bsel_i = 2'h0;
      acc1_load_i = 1;
      nx();
      panel_i = x;
      acc2_load_i = 1;
      nx();
      check(acc2_o, x);
      check(acc1_o, y);
      for (int f = 0; f < 4; f++) begin
         func_i = f[1:0];
         nx();
         e = f == 1 ? {1'b0, x} + {1'b0, y} : f == 2 ? {1'b0, x} + {1'b0, ~y} + 13'h1 : {1'b0, x};
         check({carry_o, sum_o}, e);
      end
      func_i = 2'h1;
      bsel_i = 2'h1;
      panel_i = 12'h000;
      nx();
      check(sum_o, x);
      sub1_from_acc_i = 1;
      sub2_from_acc_i = 1;
      nx();
      ea = '{x, y, x, y, last_loc, 12'h000, 12'h0A7, 12'h6A9, y, x};
      for (int i = 0; i < 10; i++) begin
         asel_i = i < 8 ? i[2:0] : 3'h7;
         usel_i = i == 8 ? 2'h0 : i == 9 ? 2'h1 : 2'h2;
         func_i = 2'h0;
         nx();
         check(sum_o, ea[i]);
      end
      asel_i = 3'h6;
      acc1_load_i = 1;
      nx();
      check(acc1_o, 12'h0A7);
      prod_load_i = 1;
      nx();
      acc1_from_sub_i = 1;
      acc2_from_sub_i = 1;
      nx();
      check(acc1_o, prod_high_i);
      check(acc2_o, prod_low_i);
      asel_i = 3'h4;
      func_i = 2'h1;
      bsel_i = 2'h0;
      pc_load_i = 1;
      nx();
      check(pc_o, last_loc + prod_high_i);
      asel_i = 3'h5;
      func_i = 2'h0;
      nx();
      check(sum_o, last_loc + prod_high_i);
   endtask : arith
   task automatic report_and_stop();
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop
   // Main sequence
   initial begin
      clr();
      {bufsel_mem_i, bufsel_hi_i, bsel_i, asel_i, usel_i, func_i, panel_i, flag_i} = '0;
      {prod_low_i, prod_high_i, periph_i, overflow_i} = {12'h3C1, 12'h5E2, 12'h6A9, 1'b1};
      {cur_field_i, jsr_field_i, int_field_i} = {2'h2, 2'h1, 2'h3};
      repeat (6) @(negedge mclk_i);
      rst_b_i = 1;
      check({acc1_o, pc_o}, 24'h000000);
      foreach (ea_addr[i]) fetch(ea_addr[i]);
      rst_b_i = 0;
      nx();
      rst_b_i = 1;
      check(mem_addr_o, 12'h000);
      // Reload a nonzero location after reset for the operand A checks
      fetch(ea_addr[1]);
      ir_ops();
      arith();
      report_and_stop();
   end
endmodule : crd_datapath_test
